/* File: core/coefficient_bank_switcher.sv */
// Operation
// - Three parameter banks; active bank picked by control register manually or by rate.
// - Each bank holds seven five-coefficient biquads per channel, all eight channels.
// - Each bank holds loudness biquad and both dynamics limiter energy/time pairs.
// - Each bank holds five bass and five treble filter-set selections.
// - Reset selects manual mode with bank one active.
// - Banks two and three reset to zero; host must program them first.
// - Manual selection codes 000, 001, 010 pick banks one, two, three.
// - Manual mode coefficient writes go into the selected bank.
// - Manual switch while streaming runs mute, swap, then unmute.
// - Switch mute overrides pending unmute or volume commands.
// - Unmute returns each channel to its latest commanded volume.
// - Switch still happens with clocks stopped, or during silent start.
// - Code 3 enables automatic selection with rate bytes for banks one, two.
// - On rate change pick bank one, else bank two, else bank three.
// - Bank one rate byte resets to ones, bank two rate byte to zeros.
// - Automatic mode coefficient writes go into the active bank.
// - Codes 4, 5, 6 direct writes to banks one to three, active unchanged.
// - Bank-set mode blocks rate-driven switches and keeps the mapping.
// - Commands are stored and status read even without master clock.
`timescale 1ns/10ps
`include "bank_switch_defs.svh"
module coefficient_bank_switcher
  import bank_switch_pkg::*;
#(
  parameter int WORDS = `COEF_WORDS_INT
)
(
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  // Control port register access
  input wire reg_req_t req_i,
  output logic [31:0] rdata_o,
  output logic rvalid_o,
  // Audio clock status and rate detection
  input wire logic clk_present_i,
  input wire logic streaming_i,
  input wire logic [7:0] rate_onehot_i,
  input wire logic rate_change_i,
  // Mute ramp handshake
  input wire logic mute_done_i,
  input wire logic unmute_done_i,
  output logic switch_mute_o,
  output logic switch_unmute_o,
  // Active bank and switch-in-progress flag for the processor
  output logic [1:0] active_bank_o,
  output logic switching_o
);
  logic [31:0] coef_mem [0:3*WORDS-1];
  logic [31:0] bank_ctrl;
  logic [31:0] next_bank_ctrl;
  bank_t active;
  bank_t next_active;
  bank_t target;
  bank_t next_target;
  sw_state_t state;
  sw_state_t next_state;
  logic [2:0] clk_sync;
  logic [2:0] next_clk_sync;
  logic clk_ok;
  logic next_clk_ok;
  logic [31:0] next_rdata;
  logic next_rvalid;
  logic switch_req;
  bank_t switch_bank;
  bank_t write_bank;
  logic coef_hit;
  logic [7:0] coef_idx;
  logic [2:0] sel;
  logic [2:0] new_sel;
  logic coef_we;
  int coef_addr;
  logic next_switch_mute;
  logic next_switch_unmute;
  logic next_switching;

  assign sel = bank_ctrl[`SEL_LSB +: 3];
  assign new_sel = req_i.data[`SEL_LSB +: 3];

  // Map the sparse coefficient addresses onto a dense per-bank index.
  always_comb
  begin
    coef_hit = 1'b1;
    coef_idx = 8'h00;
    if (req_i.addr >= `BIQUAD_FIRST_ADDR && req_i.addr <= `BIQUAD_LAST_ADDR)
      coef_idx = req_i.addr - `BIQUAD_FIRST_ADDR;
    else
      case (req_i.addr)
        `LOUDNESS_ADDR: coef_idx = `COEF_WORDS - 8'h09;
        `LIMONE_ENERGY_ADDR: coef_idx = `COEF_WORDS - 8'h08;
        `LIMONE_TIME_ADDR: coef_idx = `COEF_WORDS - 8'h07;
        `LIMTWO_ENERGY_ADDR: coef_idx = `COEF_WORDS - 8'h06;
        `LIMTWO_TIME_ADDR: coef_idx = `COEF_WORDS - 8'h05;
        `BASS_ADDR: coef_idx = `COEF_WORDS - 8'h04;
        `TREBLE_ADDR: coef_idx = `COEF_WORDS - 8'h03;
        default: coef_hit = 1'b0;
      endcase
  end

  // Writes go to the bank-set target in bank-set mode, otherwise to the active bank.
  always_comb
  begin
    case (sel)
      `SEL_SET1: write_bank = BANK_ONE;
      `SEL_SET2: write_bank = BANK_TWO;
      `SEL_SET3: write_bank = BANK_THREE;
      default: write_bank = active;
    endcase
  end

  // Write decode for the coefficient array; the array register below only stores.
  always_comb
  begin
    coef_we = req_i.valid && req_i.write && coef_hit;
    coef_addr = int'(write_bank) * WORDS + int'(coef_idx);
  end

  // Coefficient storage; every bank clears at reset, so banks two and three read zero.
  always_ff @(posedge core_clk_i)
  begin
    for (int i = 0; i < 3*WORDS; i++)
      if (!reset_n_i)
        coef_mem[i] <= 32'h0000_0000;
      else if (coef_we && i == coef_addr)
        coef_mem[i] <= req_i.data;
  end

  // Control register and switch requests.
  always_comb
  begin
    next_bank_ctrl = bank_ctrl;
    switch_req = 1'b0;
    switch_bank = active;
    if (req_i.valid && req_i.write && req_i.addr == `BANK_CTRL_ADDR)
    begin
      if (new_sel == 3'h7)
        next_bank_ctrl = {bank_ctrl[31:19], sel, req_i.data[15:0]};
      else
        next_bank_ctrl = req_i.data;
      case (new_sel)
        `SEL_BANK1: switch_bank = BANK_ONE;
        `SEL_BANK2: switch_bank = BANK_TWO;
        `SEL_BANK3: switch_bank = BANK_THREE;
        default: switch_bank = active;
      endcase
      switch_req = (new_sel <= `SEL_BANK3) && (switch_bank != active);
    end
    // Only automatic mode reacts to rate changes, so bank-set mode never switches here.
    else if (sel == `SEL_AUTO && rate_change_i)
    begin
      // Priority scan: bank one first, then bank two, else bank three.
      if ((bank_ctrl[`RATE1_LSB +: 8] & rate_onehot_i) != 8'h00)
        switch_bank = BANK_ONE;
      else if ((bank_ctrl[`RATE2_LSB +: 8] & rate_onehot_i) != 8'h00)
        switch_bank = BANK_TWO;
      else
        switch_bank = BANK_THREE;
      switch_req = (switch_bank != active);
    end
  end

  // Switch sequencer. Bank-set codes never raise a request, so no switch starts.
  always_comb
  begin
    next_state = state;
    next_active = active;
    next_target = target;
    case (state)
      SW_IDLE:
        // A manual code written from bank-set mode ends that mode and is honoured.
        if (switch_req)
        begin
          next_target = switch_bank;
          if (!clk_ok)
            next_state = SW_WAIT_CLK;
          else if (streaming_i)
            next_state = SW_MUTE;
          else
          begin
            next_active = switch_bank;
          end
        end
      SW_MUTE:
        if (mute_done_i)
          next_state = SW_SWAP;
      SW_SWAP:
      begin
        next_active = target;
        next_state = SW_UNMUTE;
      end
      SW_UNMUTE:
        if (unmute_done_i)
          next_state = SW_IDLE;
      SW_WAIT_CLK:
      begin
        // With clocks stopped the swap is immediate; restart happens in silent start.
        next_active = target;
        next_state = SW_IDLE;
      end
      default: next_state = SW_IDLE;
    endcase
  end

  // Readback works from the control clock alone, whatever the audio clocks do.
  always_comb
  begin
    next_rvalid = req_i.valid && !req_i.write;
    // Read data stands until the next read, so a slow host can still collect it.
    next_rdata = rdata_o;
    if (next_rvalid)
    begin
      if (req_i.addr == `BANK_CTRL_ADDR)
        next_rdata = bank_ctrl;
      else if (coef_hit)
        next_rdata = coef_mem[coef_addr];
      else
        next_rdata = 32'h0000_0000;
    end
  end

  always_ff @(posedge core_clk_i)
  begin
    if (!reset_n_i)
    begin
      rdata_o <= 32'h0000_0000;
      rvalid_o <= 1'b0;
    end
    else
    begin
      rdata_o <= next_rdata;
      rvalid_o <= next_rvalid;
    end
  end

  // A change of clock presence counts only once the second and third stages agree.
  always_comb
  begin
    next_clk_sync = {clk_sync[1:0], clk_present_i};
    next_clk_ok = (clk_sync[2] == clk_sync[1]) ? clk_sync[2] : clk_ok;
  end

  always_ff @(posedge core_clk_i)
  begin
    if (!reset_n_i)
    begin
      clk_sync <= 3'h0;
      clk_ok <= 1'b0;
    end
    else
    begin
      clk_sync <= next_clk_sync;
      clk_ok <= next_clk_ok;
    end
  end

  // Control register; the rate bytes start out mapping every rate to bank one.
  always_ff @(posedge core_clk_i)
  begin
    if (!reset_n_i)
      bank_ctrl <= `BANK_CTRL_RESET;
    else
      bank_ctrl <= next_bank_ctrl;
  end

  always_ff @(posedge core_clk_i)
  begin
    if (!reset_n_i)
    begin
      active <= BANK_ONE;
      target <= BANK_ONE;
      state <= SW_IDLE;
    end
    else
    begin
      active <= next_active;
      target <= next_target;
      state <= next_state;
    end
  end

  // Output flags are taken from the next state so they line up with the sequencer.
  always_comb
  begin
    // Mute is held through the swap so volume or unmute commands cannot leak in.
    next_switch_mute = (next_state == SW_MUTE) || (next_state == SW_SWAP);
    next_switch_unmute = (next_state == SW_UNMUTE);
    next_switching = (next_state != SW_IDLE);
  end

  always_ff @(posedge core_clk_i)
  begin
    if (!reset_n_i)
    begin
      switch_mute_o <= 1'b0;
      switch_unmute_o <= 1'b0;
      active_bank_o <= 2'h0;
      switching_o <= 1'b0;
    end
    else
    begin
      switch_mute_o <= next_switch_mute;
      switch_unmute_o <= next_switch_unmute;
      active_bank_o <= next_active;
      switching_o <= next_switching;
    end
  end
endmodule : coefficient_bank_switcher

/* File: shared/bank_switch_defs.svh */
`ifndef BANK_SWITCH_DEFS_SVH
`define BANK_SWITCH_DEFS_SVH
`define BANK_CTRL_ADDR 8'h40
`define BIQUAD_FIRST_ADDR 8'h51
`define BIQUAD_LAST_ADDR 8'h88
`define LOUDNESS_ADDR 8'h95
`define LIMONE_ENERGY_ADDR 8'h98
`define LIMONE_TIME_ADDR 8'h9c
`define LIMTWO_ENERGY_ADDR 8'h9d
`define LIMTWO_TIME_ADDR 8'ha1
`define BASS_ADDR 8'hda
`define TREBLE_ADDR 8'hdc
`define SEL_LSB 16
`define RATE1_LSB 8
`define RATE2_LSB 0
`define SEL_BANK1 3'h0
`define SEL_BANK2 3'h1
`define SEL_BANK3 3'h2
`define SEL_AUTO 3'h3
`define SEL_SET1 3'h4
`define SEL_SET2 3'h5
`define SEL_SET3 3'h6
`define BANK_CTRL_RESET 32'h0000_ff00
`define COEF_WORDS 8'h43
`define COEF_WORDS_INT 67
`endif

/* File: shared/bank_switch_pkg.sv */
package bank_switch_pkg;
  typedef enum logic [1:0] {BANK_ONE = 2'h0, BANK_TWO = 2'h1, BANK_THREE = 2'h2} bank_t;
  typedef struct packed {
    logic valid;
    logic write;
    logic [7:0] addr;
    logic [31:0] data;
  } reg_req_t;
  typedef enum logic [4:0] {
    SW_IDLE = 5'b00001,
    SW_MUTE = 5'b00010,
    SW_SWAP = 5'b00100,
    SW_UNMUTE = 5'b01000,
    SW_WAIT_CLK = 5'b10000
  } sw_state_t;
endpackage : bank_switch_pkg

/* File: verif/bank_switch_checker.sv */
`timescale 1ns/10ps
`include "bank_switch_defs.svh"
module bank_switch_checker
  import bank_switch_pkg::*;
(
  // Watched ports
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  input wire reg_req_t req_i,
  input wire logic clk_present_i,
  input wire logic streaming_i,
  input wire logic mute_done_i,
  input wire logic rvalid_o,
  input wire logic switch_mute_o,
  input wire logic switch_unmute_o,
  input wire logic [1:0] active_bank_o,
  input wire logic switching_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!reset_n_i);
  logic sel_wr;
  logic [2:0] sel;
  // Switch requests from writes during a running sequence are dropped, so only idle writes are judged.
  assign sel_wr = req_i.valid && req_i.write && req_i.addr == `BANK_CTRL_ADDR && !switching_o;
  assign sel = req_i.data[18:16];
  a_bank_range: assert property (active_bank_o != 2'h3) else $error("bad bank");
  a_read_answer: assert property (req_i.valid && !req_i.write |=> rvalid_o)
    else $error("no answer");
  a_mute_wins: assert property (!(switch_mute_o && switch_unmute_o))
    else $error("mute and unmute");
  a_mute_holds: assert property (switch_mute_o && !mute_done_i && !$past(mute_done_i)
    |=> switch_mute_o)
    else $error("mute dropped");
  a_swap_in_mute: assert property (streaming_i && $changed(active_bank_o)
    |-> switch_unmute_o && $past(switch_mute_o)) else $error("swap unmuted");
  a_set_holds: assert property (sel_wr && sel[2] |=> $stable(active_bank_o))
    else $error("set mode switched");
  a_manual_quiet: assert property (sel_wr && sel < 3'h3 && !streaming_i && clk_present_i
    |=> active_bank_o == $past(sel[1:0])) else $error("manual select");
  a_manual_mutes: assert property (sel_wr && sel < 3'h3 && streaming_i && clk_present_i
    && sel[1:0] != active_bank_o |=> switch_mute_o && switching_o) else $error("no mute");
endmodule : bank_switch_checker
bind coefficient_bank_switcher bank_switch_checker bank_switch_checker_i (
  .core_clk_i(core_clk_i), .reset_n_i(reset_n_i), .req_i(req_i),
  .clk_present_i(clk_present_i), .streaming_i(streaming_i), .mute_done_i(mute_done_i),
  .rvalid_o(rvalid_o), .switch_mute_o(switch_mute_o), .switch_unmute_o(switch_unmute_o),
  .active_bank_o(active_bank_o), .switching_o(switching_o));

/* File: verif/ramp_model.sv */
`timescale 1ns/10ps
module ramp_model #(
  parameter int DLY = 4
)
(
  // Ramp handshake
  input wire logic clk_i,
  input wire logic mute_req_i,
  input wire logic unmute_req_i,
  output logic mute_done_o = 1'b0,
  output logic unmute_done_o = 1'b0
);
  int cnt = 0;
  // A fixed ramp span keeps the mute visible for several cycles.
  always @(posedge clk_i)
  begin
    mute_done_o <= mute_req_i && cnt == DLY;
    unmute_done_o <= unmute_req_i && cnt == DLY;
    cnt <= (mute_req_i || unmute_req_i) && cnt < DLY ? cnt + 1 : 0;
  end
endmodule : ramp_model

/* File: verif/tb_top.sv */
`timescale 1ns/10ps
module tb_top;
  import bank_switch_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  reg_req_t req = '0;
  logic stream = 1'b0;
  logic [7:0] rate = 8'h00;
  logic rchg = 1'b0;
  logic clkp = 1'b1;
  logic mdone, udone, smute, sunmute, rvalid, busy;
  logic [31:0] rdata;
  logic [1:0] bank;
  logic [7:0] rts [3] = '{8'h20, 8'h01, 8'h80};
  logic [1:0] exb [3] = '{2'h1, 2'h0, 2'h2};
  int n_errors = 0;
  int samples_checked = 0;
  coefficient_bank_switcher coefficient_bank_switcher_i (.core_clk_i(clk), .reset_n_i(rst_n),
    .req_i(req), .rdata_o(rdata), .rvalid_o(rvalid), .clk_present_i(clkp),
    .streaming_i(stream), .rate_onehot_i(rate), .rate_change_i(rchg), .mute_done_i(mdone),
    .unmute_done_i(udone), .switch_mute_o(smute), .switch_unmute_o(sunmute),
    .active_bank_o(bank), .switching_o(busy));
  ramp_model ramp_model_i (.clk_i(clk), .mute_req_i(smute), .unmute_req_i(sunmute),
    .mute_done_o(mdone), .unmute_done_o(udone));
  initial forever #20 clk = ~clk;
  task close_out;
    $display("errors %0d checks %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : close_out
  task chk(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e)
    begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk
  task wr(input logic [7:0] a, input logic [31:0] d);
    req = '{1'b1, 1'b1, a, d};
    @(posedge clk);
    #1 req = '0;
    @(posedge clk);
    #1;
  endtask : wr
  task rd(input logic [7:0] a, input logic [31:0] e);
    req = '{1'b1, 1'b0, a, 32'h0};
    @(posedge clk);
    #1 req = '0;
    chk(rvalid, 1);
    chk(rdata, e);
    @(posedge clk);
    #1;
  endtask : rd
  // The real hold-off after a switch is far longer; here the host waits for idle only.
  task settle(input logic [1:0] e);
    repeat (60) if (busy !== 1'b0) @(posedge clk) #1;
    chk(busy, 0);
    chk(bank, e);
  endtask : settle
  task new_rate(input logic [7:0] r);
    rate = r;
    rchg = 1'b1;
    @(posedge clk);
    #1 rchg = 1'b0;
  endtask : new_rate
  initial
  begin
    #200000;
    n_errors++;
    close_out;
  end
  initial
  begin
    repeat (10) @(posedge clk);
    #1 rst_n = 1'b1;
    chk(bank, 0);
    rd(8'h40, 32'h0000_ff00);
    wr(8'h40, 32'h0005_ff00);
    wr(8'h51, 32'h0000_00a5);
    rd(8'h51, 32'h0000_00a5);
    wr(8'h40, 32'h0007_0f30);
    rd(8'h40, 32'h0005_0f30);
    wr(8'h40, 32'h0006_0f30);
    wr(8'h98, 32'h0000_0098);
    chk(bank, 0);
    rd(8'h50, 0);
    wr(8'h40, 32'h0001_0f30);
    chk(bank, 1);
    rd(8'h51, 32'h0000_00a5);
    rd(8'h52, 0);
    stream = 1'b1;
    wr(8'h40, 32'h0002_0f30);
    chk({smute, busy, bank}, 4'hd);
    repeat (20) if (sunmute !== 1'b1) @(posedge clk) #1;
    chk({smute, sunmute, bank}, 4'h6);
    settle(2);
    rd(8'h98, 32'h0000_0098);
    wr(8'h40, 32'h0003_0f30);
    for (int i = 0; i < 3; i++)
    begin
      new_rate(rts[i]);
      settle(exb[i]);
    end
    wr(8'h40, 32'h0004_0f30);
    new_rate(8'h20);
    settle(2);
    wr(8'h40, 32'h0003_0f30);
    new_rate(8'h01);
    settle(0);
    stream = 1'b0;
    clkp = 1'b0;
    repeat (5) @(posedge clk);
    #1;
    wr(8'h40, 32'h0002_0f30);
    chk(bank, 2);
    close_out;
  end
endmodule : tb_top
